//--- pkg/aar_pkg.sv
// Purpose: constants and carriers for the alarm aggregator
// Assumes: 20 MHz clock, 1 ms persistence tick
// Notes:   register offsets are byte addresses on APB
package aar_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
  // analog current limits in microamps
  localparam logic [15:0] AIN_LOW_UA   = 16'h07d0;
  localparam logic [15:0] AIN_HIGH_UA  = 16'h55f0;
  // delay limits in ticks of 1 ms, speed limit in rpm
  localparam logic [15:0] AIN_DLY_MIN  = 16'h000a;
  localparam logic [15:0] AIN_DLY_MAX  = 16'hea60;
  localparam logic [15:0] REG_DLY_MAX  = 16'hffff;
  localparam logic [15:0] RPM_MAX      = 16'h0898;
  // source bit positions
  localparam int unsigned NSRC         = 15;
  localparam int unsigned S_PICK1 = 0;
  localparam int unsigned S_PICK2 = 1;
  localparam int unsigned S_REMOTE = 2;
  localparam int unsigned S_TORQ_IN = 3;
  localparam int unsigned S_RACK = 4;
  localparam int unsigned S_HIGH = 5;
  localparam int unsigned S_LINKA = 6;
  localparam int unsigned S_LINKB = 7;
  localparam int unsigned S_LINKAB = 8;
  localparam int unsigned S_REGLOW = 9;
  localparam int unsigned S_OVSPD = 10;
  localparam int unsigned S_CLUTCH = 11;
  localparam int unsigned S_MODE = 12;
  localparam int unsigned S_TORQDEV = 13;
  localparam int unsigned S_CURDEV = 14;
  // APB register byte offsets
  localparam logic [7:0] A_MIN_EN   = 8'h00;
  localparam logic [7:0] A_MAJ_EN   = 8'h04;
  localparam logic [7:0] A_CTRL     = 8'h08;
  localparam logic [7:0] A_AIN_DLY  = 8'h0c;
  localparam logic [7:0] A_REG_LVL  = 8'h10;
  localparam logic [7:0] A_REG_TIM  = 8'h14;
  localparam logic [7:0] A_HIGH_LVL = 8'h18;
  localparam logic [7:0] A_OVSPD    = 8'h1c;
  localparam logic [7:0] A_LINK_DLY = 8'h20;
  localparam logic [7:0] A_MODE_DLY = 8'h24;
  localparam logic [7:0] A_CLU_TIM  = 8'h28;
  localparam logic [7:0] A_FLAGS    = 8'h2c;
  localparam logic [7:0] A_IRQ_ST   = 8'h30;
  localparam logic [7:0] A_IRQ_MSK  = 8'h34;
  // control bits
  localparam int unsigned C_MIN_POL = 0;
  localparam int unsigned C_MAJ_POL = 1;
  localparam int unsigned C_DECL    = 2;
  localparam int unsigned C_RESET   = 3;
  // reset values
  localparam logic [15:0] AIN_DLY_RST = 16'h03e8;
  localparam logic [15:0] DLY_RST     = 16'h03e8;
  localparam logic [15:0] RPM_RST     = 16'h0898;
  localparam logic [15:0] PCT_RST     = 16'h03e8;
  typedef struct packed {
    logic        pick1;
    logic        pick2;
    logic        link_a;
    logic        link_b;
    logic        port3;
    logic        mode_closed;
    logic        clutch_req;
    logic        clutch_engaged;
    logic        torq_dev;
    logic        cur_dev;
  } aar_disc_s;
  typedef struct packed {
    logic [15:0] remote_ua;
    logic [15:0] torque_ua;
    logic [15:0] rack_ua;
    logic [15:0] pid_pm;
    logic [15:0] speed_rpm;
  } aar_meas_s;
endpackage

//--- src/aar_top.sv
// Purpose: alarm aggregation and relay drive for a governor
// Assumes: one clock, inputs synchronous; APB register access
// Notes:   percent values in tenths, times in ms ticks
// How it works
// R1: minor relay follows OR of all enabled latched sources
// R2: pickup, remote, torque, rack failures gated by own enables
// R3: analog failed after out-of-window for failure delay
// R4: minor polarity true inverts minor relay drive
// R5: major polarity true inverts major relay drive
// R6: regulator low fault after below threshold for persist time
// R7: declutch output asserted on regulator low when option set
// R8: high drive fault when regulator output above threshold
// R9: overspeed fault when speed above setpoint
// R10: link faults persist for link delay before latching
// R11: mode contact persists for mode delay before latching
// R12: clutch fail if engaged not seen within sync time
// R13: mode source feeds alarm while contact closed and enabled
// R14: both-link source is AND of channel faults, gated by enable
// R15: torque and current deviation gated by own enables
// R16: rising reset control clears latches whose cause cleared
// R17: timers count 1 ms tick and restart when cause drops
// R18: latches hold until reset; all clear on reset
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module aar_top #(
  parameter int unsigned TICK = aar_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // fault inputs
  input  wire aar_pkg::aar_disc_s disc,
  input  wire aar_pkg::aar_meas_s meas,
  // relays and outputs
  output logic                   minor_relay,
  output logic                   major_relay,
  output logic                   declutch,
  output logic                   irq
);
  // the tick counter is 16 bits and a tick must not fire every cycle
  if (TICK < 2 || TICK > 65536) begin : g_bad_tick
    $error("tick divider out of range");
  end
  localparam int unsigned N = aar_pkg::NSRC;

  logic [N-1:0]  min_en_reg, maj_en_reg, latch_reg, raw, irq_st_reg;
  logic [N-1:0]  irq_msk_reg;
  logic [3:0]    ctrl_reg;
  logic [15:0]   ain_dly_reg, reg_lvl_reg, reg_tim_reg, high_lvl_reg;
  logic [15:0]   ovspd_reg, link_dly_reg, mode_dly_reg, clu_tim_reg;
  logic [15:0]   tick_cnt_reg;
  logic          tick;
  logic          rst_prev_reg;
  logic          rst_pulse;
  logic          wr;
  logic [31:0]   rd_next;
  logic          err_next;

  // tick divider for persistence timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 16'(TICK - 1)); // R17

  // persistence conditions and their delays
  logic [7:0]        cond;
  logic [7:0][15:0]  lim;
  logic [7:0][15:0]  tcnt_reg;
  logic [7:0]        done;
  function automatic logic out_win(input logic [15:0] ua);
    out_win = (ua < aar_pkg::AIN_LOW_UA) || (ua > aar_pkg::AIN_HIGH_UA);
  endfunction
  always_comb begin
    cond[0] = out_win(meas.remote_ua); // R3
    cond[1] = out_win(meas.torque_ua); // R3
    cond[2] = out_win(meas.rack_ua); // R3
    cond[3] = meas.pid_pm < reg_lvl_reg; // R6
    cond[4] = disc.link_a; // R10
    cond[5] = disc.link_b; // R10
    cond[6] = disc.mode_closed; // R11
    cond[7] = disc.port3; // R10
    lim[0] = ain_dly_reg;
    lim[1] = ain_dly_reg;
    lim[2] = ain_dly_reg;
    lim[3] = reg_tim_reg;
    lim[4] = link_dly_reg;
    lim[5] = link_dly_reg;
    lim[6] = mode_dly_reg;
    lim[7] = link_dly_reg;
  end
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_tmr
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          tcnt_reg[g] <= 16'h0000;
        end else if (!cond[g]) begin
          tcnt_reg[g] <= 16'h0000; // R17
        end else if (tick && tcnt_reg[g] < lim[g]) begin
          tcnt_reg[g] <= tcnt_reg[g] + 16'h0001; // R17
        end
      end
      assign done[g] = cond[g] && (tcnt_reg[g] >= lim[g]);
    end
  endgenerate

  // clutch sync timer, runs while request pending without engaged
  logic [15:0] clu_cnt_reg;
  logic        clu_wait;
  assign clu_wait = disc.clutch_req && !disc.clutch_engaged;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clu_cnt_reg <= 16'h0000;
    end else if (!clu_wait) begin
      clu_cnt_reg <= 16'h0000;
    end else if (tick && clu_cnt_reg < clu_tim_reg) begin
      clu_cnt_reg <= clu_cnt_reg + 16'h0001; // R12
    end
  end

  // raw fault sources
  always_comb begin
    raw = '0;
    raw[aar_pkg::S_PICK1]   = disc.pick1; // R2
    raw[aar_pkg::S_PICK2]   = disc.pick2; // R2
    raw[aar_pkg::S_REMOTE]  = done[0]; // R2
    raw[aar_pkg::S_TORQ_IN] = done[1]; // R2
    raw[aar_pkg::S_RACK]    = done[2]; // R2
    raw[aar_pkg::S_HIGH]    = meas.pid_pm > high_lvl_reg; // R8
    raw[aar_pkg::S_LINKA]   = done[4] || done[7]; // R10
    raw[aar_pkg::S_LINKB]   = done[5]; // R10
    raw[aar_pkg::S_LINKAB]  = done[4] && done[5]; // R14
    raw[aar_pkg::S_REGLOW]  = done[3]; // R6
    raw[aar_pkg::S_OVSPD]   = meas.speed_rpm > ovspd_reg; // R9
    raw[aar_pkg::S_CLUTCH]  = clu_wait && (clu_cnt_reg >= clu_tim_reg); // R12
    raw[aar_pkg::S_MODE]    = done[6]; // R13
    raw[aar_pkg::S_TORQDEV] = disc.torq_dev; // R15
    raw[aar_pkg::S_CURDEV]  = disc.cur_dev; // R15
  end

  // reset control edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_prev_reg <= 1'b0;
    end else begin
      rst_prev_reg <= ctrl_reg[aar_pkg::C_RESET];
    end
  end
  assign rst_pulse = ctrl_reg[aar_pkg::C_RESET] && !rst_prev_reg;

  // fault latches: set wins, release only on reset edge once clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= '0; // R18
    end else if (rst_pulse) begin
      latch_reg <= raw; // R16
    end else begin
      latch_reg <= latch_reg | raw; // R18
    end
  end

  // relay and declutch drive
  logic minor_act, major_act;
  assign minor_act = |(latch_reg & min_en_reg); // R1
  assign major_act = |(latch_reg & maj_en_reg);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      minor_relay <= 1'b0;
      major_relay <= 1'b0;
      declutch    <= 1'b0;
    end else begin
      minor_relay <= minor_act ^ ctrl_reg[aar_pkg::C_MIN_POL]; // R4
      major_relay <= major_act ^ ctrl_reg[aar_pkg::C_MAJ_POL]; // R5
      declutch    <= ctrl_reg[aar_pkg::C_DECL] &&
                     latch_reg[aar_pkg::S_REGLOW]; // R7
    end
  end

  // apb register writes
  assign wr = psel && penable && pwrite;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      min_en_reg   <= '0;
      maj_en_reg   <= '0;
      ctrl_reg     <= 4'h0;
      ain_dly_reg  <= aar_pkg::AIN_DLY_RST;
      reg_lvl_reg  <= 16'h0000;
      reg_tim_reg  <= aar_pkg::DLY_RST;
      high_lvl_reg <= aar_pkg::PCT_RST;
      ovspd_reg    <= aar_pkg::RPM_RST;
      link_dly_reg <= aar_pkg::DLY_RST;
      mode_dly_reg <= aar_pkg::DLY_RST;
      clu_tim_reg  <= aar_pkg::DLY_RST;
      irq_msk_reg  <= '0;
    end else if (wr && !err_next) begin
      case (paddr)
        aar_pkg::A_MIN_EN:   min_en_reg   <= pwdata[N-1:0];
        aar_pkg::A_MAJ_EN:   maj_en_reg   <= pwdata[N-1:0];
        aar_pkg::A_CTRL:     ctrl_reg     <= pwdata[3:0];
        aar_pkg::A_AIN_DLY:  ain_dly_reg  <= pwdata[15:0];
        aar_pkg::A_REG_LVL:  reg_lvl_reg  <= pwdata[15:0];
        aar_pkg::A_REG_TIM:  reg_tim_reg  <= pwdata[15:0];
        aar_pkg::A_HIGH_LVL: high_lvl_reg <= pwdata[15:0];
        aar_pkg::A_OVSPD:    ovspd_reg    <= pwdata[15:0];
        aar_pkg::A_LINK_DLY: link_dly_reg <= pwdata[15:0];
        aar_pkg::A_MODE_DLY: mode_dly_reg <= pwdata[15:0];
        aar_pkg::A_CLU_TIM:  clu_tim_reg  <= pwdata[15:0];
        aar_pkg::A_IRQ_MSK:  irq_msk_reg  <= pwdata[N-1:0];
        default: ;
      endcase
    end
  end

  // access check: failure delay and setpoint write limits, address past IRQ mask or unaligned
  always_comb begin
    err_next = 1'b0;
    if (psel && pwrite && paddr == aar_pkg::A_AIN_DLY) begin
      err_next = pwdata[15:0] < aar_pkg::AIN_DLY_MIN ||
                 pwdata[15:0] > aar_pkg::AIN_DLY_MAX;
    end else if (psel && pwrite && paddr == aar_pkg::A_OVSPD) begin
      err_next = pwdata[15:0] == 16'h0000 ||
                 pwdata[15:0] > aar_pkg::RPM_MAX;
    end else if (psel && paddr > aar_pkg::A_IRQ_MSK) begin
      err_next = 1'b1;
    end else if (psel && paddr[1:0] != 2'b00) begin
      err_next = 1'b1;
    end
  end

  // sticky status: new latch events set, write one clears, set wins
  logic [N-1:0] latch_prev_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_prev_reg <= '0;
      irq_st_reg     <= '0;
      irq            <= 1'b0;
    end else begin
      latch_prev_reg <= latch_reg;
      irq_st_reg <= (irq_st_reg &
                     ~((wr && paddr == aar_pkg::A_IRQ_ST) ?
                       pwdata[N-1:0] : '0))
                    | (latch_reg & ~latch_prev_reg);
      irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  // apb read mux
  always_comb begin
    rd_next = 32'h0000_0000;
    case (paddr)
      aar_pkg::A_MIN_EN:   rd_next[N-1:0] = min_en_reg;
      aar_pkg::A_MAJ_EN:   rd_next[N-1:0] = maj_en_reg;
      aar_pkg::A_CTRL:     rd_next[3:0]   = ctrl_reg;
      aar_pkg::A_AIN_DLY:  rd_next[15:0]  = ain_dly_reg;
      aar_pkg::A_REG_LVL:  rd_next[15:0]  = reg_lvl_reg;
      aar_pkg::A_REG_TIM:  rd_next[15:0]  = reg_tim_reg;
      aar_pkg::A_HIGH_LVL: rd_next[15:0]  = high_lvl_reg;
      aar_pkg::A_OVSPD:    rd_next[15:0]  = ovspd_reg;
      aar_pkg::A_LINK_DLY: rd_next[15:0]  = link_dly_reg;
      aar_pkg::A_MODE_DLY: rd_next[15:0]  = mode_dly_reg;
      aar_pkg::A_CLU_TIM:  rd_next[15:0]  = clu_tim_reg;
      aar_pkg::A_FLAGS:    rd_next = {minor_act, major_act, 15'h0000,
                                      latch_reg};
      aar_pkg::A_IRQ_ST:   rd_next[N-1:0] = irq_st_reg;
      aar_pkg::A_IRQ_MSK:  rd_next[N-1:0] = irq_msk_reg;
      default:             rd_next = 32'h0000_0000;
    endcase
  end

  // apb answer: no wait state, pready in first access cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= rd_next;
      pslverr <= psel && !penable && err_next;
    end
  end

  // checks: relay drive and masking
  minor_or_a: assert property (@(posedge clk) disable iff (!resetn) // R1 R4
    1'b1 |=> minor_relay == ($past(minor_act) ^
      $past(ctrl_reg[aar_pkg::C_MIN_POL])))
    else $error("minor relay wrong");
  major_pol_a: assert property (@(posedge clk) disable iff (!resetn) // R5
    1'b1 |=> major_relay == ($past(major_act) ^
      $past(ctrl_reg[aar_pkg::C_MAJ_POL])))
    else $error("major relay wrong");
  minor_quiet_a: assert property (@(posedge clk) disable iff (!resetn) // R2
    (latch_reg & min_en_reg) == '0 && !ctrl_reg[aar_pkg::C_MIN_POL]
      |=> !minor_relay)
    else $error("disabled source drove minor relay");
  declutch_opt_a: assert property (@(posedge clk) disable iff (!resetn) // R7
    !ctrl_reg[aar_pkg::C_DECL] |=> !declutch)
    else $error("declutch without option");
  // checks: latches and the reset control
  latch_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R18
    (|latch_reg) && !rst_pulse |=> (latch_reg & $past(latch_reg)) ==
      $past(latch_reg))
    else $error("latch dropped");
  reset_clear_a: assert property (@(posedge clk) disable iff (!resetn) // R16
    rst_pulse |=> latch_reg == $past(raw))
    else $error("reset did not clear");
  high_drive_a: assert property (@(posedge clk) disable iff (!resetn) // R8
    meas.pid_pm > high_lvl_reg |=> latch_reg[aar_pkg::S_HIGH])
    else $error("high drive missed");
  overspd_a: assert property (@(posedge clk) disable iff (!resetn) // R9
    meas.speed_rpm > ovspd_reg |=> latch_reg[aar_pkg::S_OVSPD])
    else $error("overspeed missed");
  clutch_ok_a: assert property (@(posedge clk) disable iff (!resetn) // R12
    disc.clutch_engaged |-> !raw[aar_pkg::S_CLUTCH])
    else $error("clutch fail while engaged");
  both_link_a: assert property (@(posedge clk) disable iff (!resetn) // R14
    raw[aar_pkg::S_LINKAB] |-> disc.link_a && disc.link_b)
    else $error("both link wrong");
  // checks: persistence timers, a fault needs its cause the cycle before
  timer_restart_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    !cond[3] |=> tcnt_reg[3] == 16'h0000)
    else $error("timer not restarted");
  tick_rate_a: assert property (@(posedge clk) disable iff (!resetn) // R17
    tick |=> !tick)
    else $error("tick too fast");
  ain_persist_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    $rose(done[0]) |-> $past(cond[0]))
    else $error("analog failed early");
  reg_persist_a: assert property (@(posedge clk) disable iff (!resetn) // R6
    $rose(done[3]) && reg_tim_reg != 16'h0000 |-> $past(cond[3]))
    else $error("regulator low early");
  link_persist_a: assert property (@(posedge clk) disable iff (!resetn) // R10
    $rose(done[4]) && link_dly_reg != 16'h0000 |-> $past(cond[4]))
    else $error("link fault early");
  port3_persist_a: assert property (@(posedge clk) disable iff (!resetn) // R10
    $rose(done[7]) && link_dly_reg != 16'h0000 |-> $past(cond[7]))
    else $error("port 3 fault early");
  mode_persist_a: assert property (@(posedge clk) disable iff (!resetn) // R11
    $rose(done[6]) && mode_dly_reg != 16'h0000 |-> $past(cond[6]))
    else $error("mode contact early");
  // checks: register bus and interrupt
  pready_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    pready |=> !pready)
    else $error("ready held too long");
  slverr_ready_a: assert property (@(posedge clk) disable iff (!resetn)
    pslverr |-> pready)
    else $error("error without ready");
  ain_refused_a: assert property (@(posedge clk) disable iff (!resetn) // R3
    wr && err_next && paddr == aar_pkg::A_AIN_DLY |=> $stable(ain_dly_reg))
    else $error("refused delay written");
  spd_refused_a: assert property (@(posedge clk) disable iff (!resetn) // R9
    wr && err_next && paddr == aar_pkg::A_OVSPD |=> $stable(ovspd_reg))
    else $error("refused setpoint written");
  status_set_a: assert property (@(posedge clk) disable iff (!resetn)
    (latch_reg & ~latch_prev_reg) != '0 |=>
      (irq_st_reg & $past(latch_reg & ~latch_prev_reg)) ==
      $past(latch_reg & ~latch_prev_reg))
    else $error("status event lost");
  irq_level_a: assert property (@(posedge clk) disable iff (!resetn)
    (irq_st_reg & irq_msk_reg) != '0 |=> irq)
    else $error("interrupt missing");
endmodule // aar_top
`default_nettype wire

//--- bench/aar_panel.sv
// Purpose: annunciator panel model facing the alarm relays
// Assumes: a lamp shows the alarm state that the contact reports
// Notes:   inversion inputs mirror how the panel is wired
`timescale 1ns/1ns
`default_nettype none
module aar_panel (
  // relay contacts
  input  wire logic minor_relay,
  input  wire logic major_relay,
  // panel wiring options
  input  wire logic minor_inv,
  input  wire logic major_inv,
  // lamps
  output logic      minor_lit,
  output logic      major_lit
);
  // inverted wiring reads a dropped relay as an alarm
  assign minor_lit = minor_relay ^ minor_inv;
  assign major_lit = major_relay ^ major_inv;
endmodule // aar_panel
`default_nettype wire

//--- bench/alarm_aggregator_relay_logic_test.sv
// Purpose: self-checking bench for the alarm aggregator
// Assumes: TICK of 4 cycles, registers reached over APB
// Notes:   each source runs as a table row, odd cases follow
`timescale 1ns/1ns
`default_nettype none
module alarm_aggregator_relay_logic_test;
  typedef struct packed {
    aar_pkg::aar_disc_s d;
    aar_pkg::aar_meas_s m;
    logic [14:0]        e;
  } aar_row_s;
  localparam aar_pkg::aar_meas_s MOK =
    '{16'h2ee0, 16'h2ee0, 16'h2ee0, 16'h01f4, 16'h03e8};
  logic               clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               minor_relay, major_relay, declutch, irq, err, mi, ma;
  logic               minor_lit, major_lit;
  aar_pkg::aar_disc_s disc;
  aar_pkg::aar_meas_s meas;
  aar_row_s           rows [15];
  int                 err_count, num_checks;

  aar_top #(.TICK(4)) dut_u (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .disc(disc),
    .meas(meas), .minor_relay(minor_relay), .major_relay(major_relay),
    .declutch(declutch), .irq(irq));
  aar_panel panel_u (.minor_relay(minor_relay), .major_relay(major_relay),
    .minor_inv(mi), .major_inv(ma), .minor_lit(minor_lit),
    .major_lit(major_lit));

  // 20 MHz clock
  always #25 clk = ~clk;

  // one row per source: inputs that raise it and the flags expected
  function automatic aar_row_s mk(input int s);
    aar_row_s r;
    r.d = '0;
    r.m = MOK;
    r.e = 15'h0001 << s;
    case (s)
      0: r.d.pick1 = 1'b1;
      1: r.d.pick2 = 1'b1;
      2: r.m.remote_ua = 16'h03e8;
      3: r.m.torque_ua = 16'h59d8;
      4: r.m.rack_ua = 16'h03e8;
      5: r.m.pid_pm = 16'h03b6;
      6: r.d.link_a = 1'b1;
      7: r.d.link_b = 1'b1;
      8: r.d = 10'h0c0;
      9: r.m.pid_pm = 16'h0032;
      10: r.m.speed_rpm = 16'h0899;
      11: r.d.clutch_req = 1'b1;
      12: r.d.mode_closed = 1'b1;
      13: r.d.torq_dev = 1'b1;
      default: r.d.cur_dev = 1'b1;
    endcase
    if (s == 8) r.e = 15'h01c0;
    return r;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one APB transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // rising edge of the reset-all control bit
  task automatic ra(input logic [31:0] c);
    wr(aar_pkg::A_CTRL, c | 32'h8);
    wr(aar_pkg::A_CTRL, c);
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    disc = '0;
    meas = MOK;
    {mi, ma, err_count, num_checks} = '0;
    for (int i = 0; i < 15; i++) rows[i] = mk(i);
    cyc(5);
    chk({28'h0, minor_relay, major_relay, declutch, irq}, 32'h0);
    resetn <= 1'b1;
    rdc(aar_pkg::A_AIN_DLY, {16'h0, aar_pkg::AIN_DLY_RST});
    rdc(aar_pkg::A_OVSPD, {16'h0, aar_pkg::RPM_RST});
    wr(aar_pkg::A_AIN_DLY, 32'h9);
    chk({31'h0, err}, 32'h1);
    rdc(aar_pkg::A_AIN_DLY, {16'h0, aar_pkg::AIN_DLY_RST});
    wr(aar_pkg::A_OVSPD, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(aar_pkg::A_OVSPD, 32'h899);
    chk({31'h0, err}, 32'h1);
    rdc(8'h38, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset and refusals done");
    // configuration: all minor enables on, short delays
    wr(aar_pkg::A_MIN_EN, 32'h7fff);
    wr(aar_pkg::A_MAJ_EN, 32'h0);
    wr(aar_pkg::A_CTRL, 32'h0);
    wr(aar_pkg::A_AIN_DLY, 32'ha);
    wr(aar_pkg::A_REG_LVL, 32'h64);
    wr(aar_pkg::A_REG_TIM, 32'h2);
    wr(aar_pkg::A_HIGH_LVL, 32'h384);
    wr(aar_pkg::A_LINK_DLY, 32'h2);
    wr(aar_pkg::A_MODE_DLY, 32'h2);
    wr(aar_pkg::A_CLU_TIM, 32'h2);
    wr(aar_pkg::A_IRQ_MSK, 32'h7fff);
    foreach (rows[i]) begin
      disc <= rows[i].d;
      meas <= rows[i].m;
      cyc(120);
      rdc(aar_pkg::A_FLAGS, {2'b10, 15'h0, rows[i].e});
      chk({28'h0, minor_lit, major_relay, declutch, irq}, 32'h9);
      disc <= '0;
      meas <= MOK;
      cyc(4);
      rdc(aar_pkg::A_FLAGS, {2'b10, 15'h0, rows[i].e});
      ra(32'h0);
      rdc(aar_pkg::A_FLAGS, 32'h0);
    end
    $display("test source table done");
    // a short dropout restarts the failure timer
    wr(aar_pkg::A_IRQ_ST, 32'h7fff);
    repeat (2) begin
      meas.remote_ua <= 16'h03e8;
      cyc(30);
      meas.remote_ua <= 16'h2ee0;
      cyc(5);
    end
    rdc(aar_pkg::A_FLAGS, 32'h0);
    meas.remote_ua <= 16'h03e8;
    cyc(80);
    rdc(aar_pkg::A_FLAGS, 32'h80000004);
    rdc(aar_pkg::A_IRQ_ST, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(aar_pkg::A_IRQ_MSK, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(aar_pkg::A_IRQ_MSK, 32'h7fff);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    meas <= MOK;
    ra(32'h0);
    wr(aar_pkg::A_IRQ_ST, 32'h4);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    $display("test persistence and interrupt done");
    // enable gating, relay polarity, reset with cause still present
    wr(aar_pkg::A_MIN_EN, 32'h5fff);
    disc.torq_dev <= 1'b1;
    cyc(20);
    rdc(aar_pkg::A_FLAGS, 32'h2000);
    chk({31'h0, minor_relay}, 32'h0);
    wr(aar_pkg::A_MAJ_EN, 32'h2000);
    cyc(4);
    chk({31'h0, major_relay}, 32'h1);
    wr(aar_pkg::A_CTRL, 32'h3);
    mi <= 1'b1;
    ma <= 1'b1;
    cyc(4);
    chk({28'h0, minor_relay, major_relay, minor_lit, major_lit}, 32'h9);
    ra(32'h3);
    rdc(aar_pkg::A_FLAGS, 32'h40002000);
    disc <= '0;
    ra(32'h0);
    wr(aar_pkg::A_MAJ_EN, 32'h0);
    mi <= 1'b0;
    ma <= 1'b0;
    $display("test gating and polarity done");
    // regulator low with declutch option set
    wr(aar_pkg::A_CTRL, 32'h4);
    meas.pid_pm <= 16'h0032;
    cyc(20);
    chk({30'h0, minor_relay, declutch}, 32'h3);
    meas <= MOK;
    cyc(4);
    ra(32'h4);
    $display("test declutch done");
    // clutch engaged in time, port 3 link fault held for the link delay
    disc <= 10'h00c;
    cyc(20);
    rdc(aar_pkg::A_FLAGS, 32'h0);
    disc <= 10'h020;
    cyc(2);
    rdc(aar_pkg::A_FLAGS, 32'h0);
    cyc(20);
    rdc(aar_pkg::A_FLAGS, 32'h80000040);
    disc <= '0;
    ra(32'h4);
    $display("test clutch and port 3 done");
    // reset in mid-run with a source active
    disc.pick1 <= 1'b1;
    cyc(4);
    chk({31'h0, minor_relay}, 32'h1);
    resetn <= 1'b0;
    cyc(2);
    chk({28'h0, minor_relay, major_relay, declutch, irq}, 32'h0);
    disc <= '0;
    resetn <= 1'b1;
    rdc(aar_pkg::A_MIN_EN, 32'h0);
    rdc(aar_pkg::A_FLAGS, 32'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule // alarm_aggregator_relay_logic_test
`default_nettype wire
